// file: rtl/data_link_pkg.sv
package data_link_pkg;

  localparam int APB_AW = 12;
  localparam int DATA_W = 32;

  // The control register index and the status register index; byte address is four times each.
  localparam logic [11:0] CTRL_INDEX = 12'h0143;
  localparam logic [11:0] CTRL_ADDR = 12'(CTRL_INDEX << 2);
  localparam logic [11:0] STATUS_INDEX = 12'h01F8;
  localparam logic [11:0] STATUS_ADDR = 12'(STATUS_INDEX << 2);

  // Control register bit positions.
  localparam int BIT_MSG_TYPE = 0;
  localparam int BIT_TX_CHECK = 1;
  localparam int BIT_TX_IDLE = 2;
  localparam int BIT_TX_ABORT = 3;
  localparam int BIT_DUP_DISCARD = 4;
  localparam int BIT_RX_CHECK_OFF = 5;
  localparam int BIT_AUTO_ABORT_OFF = 6;
  localparam int BIT_RESERVED = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h7F;

  // Status register layout: tx state in bits 2:0, then receive flags.
  localparam int STAT_RX_IN_FRAME = 3;
  localparam int STAT_STORE_VALID = 4;
  localparam int STAT_RX_BANK = 5;

  // Octets sent least significant bit first.
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [7:0] ABORT_OCTET = 8'hFE;
  localparam logic [7:0] ONES_OCTET = 8'hFF;

  // Frame check sequence, reflected form.
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] ABORT_RUN = 3'h7;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Frame store: two banks of 64 octets.
  localparam int STORE_AW = 7;
  localparam int STORE_WORDS = 128;
  localparam logic [6:0] STORE_LIMIT = 7'h40;
  localparam logic [6:0] COUNT_MAX = 7'h7F;

  typedef enum logic [2:0] {
    TX_FLAG = 3'b000,
    TX_DATA = 3'b001,
    TX_FCS = 3'b011,
    TX_ABORT = 3'b010,
    TX_ONES = 3'b110,
    TX_BOS = 3'b100
  } tx_state_e;

endpackage

// file: rtl/frame_store.sv
module frame_store (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [data_link_pkg::STORE_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [data_link_pkg::STORE_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  import data_link_pkg::*;

  logic [7:0] mem [STORE_WORDS];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Read data leaves through a register.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// file: rtl/data_link_two.sv
// Summary of operation
// - abort sent on switch to bit signaling.
// - no abort when auto abort is off.
// - receive check sequence verified unless disabled.
// - duplicate frames discarded when discard enabled.
// - forced abort sends seven or more ones.
// - idle bit sends flags, suppressing frames.
// - flags fill channel when nothing waits.
// - idle ignored under bit oriented signaling.
// - check octets appended when enable set.
// - check enable ignored under bit signaling.
// - type bit selects bit or message signaling.
module data_link_two (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [data_link_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [data_link_pkg::DATA_W-1:0] pwdata,
  output logic [data_link_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dlTick,
  output logic txBit,
  input wire logic rxBit,
  input wire logic txMsgValid,
  input wire logic [7:0] txMsgData,
  input wire logic txMsgLast,
  output logic txMsgTake,
  input wire logic [5:0] bosCode,
  output logic [7:0] rxData,
  output logic rxDataValid,
  output logic rxFrameDone,
  output logic rxFrameAbort,
  output logic rxFcsError,
  output logic rxDuplicate,
  output logic [5:0] rxBosCode,
  output logic rxBosValid
);
  import data_link_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tx_state_e txState;
    logic [7:0] txShift;
    logic [2:0] txBitCnt;
    logic [2:0] txOnes;
    logic txBit;
    logic [15:0] txCrc;
    logic txPhase;
    logic txLastSent;
    logic txTake;
    logic [15:0] rxHist;
    logic [2:0] rxOnes;
    logic [7:0] rxShift;
    logic [2:0] rxBitCnt;
    logic rxInFrame;
    logic [6:0] rxByteCnt;
    logic [15:0] rxCrc;
    logic [15:0] rxCrcAtByte;
    logic rxMatch;
    logic rxLong;
    logic rxBank;
    logic [6:0] rxLen0;
    logic [6:0] rxLen1;
    logic rxStoreValid;
    logic [7:0] rxData;
    logic rxDataValid;
    logic rxFrameDone;
    logic rxFrameAbort;
    logic rxFcsError;
    logic rxDuplicate;
    logic [5:0] rxBosCode;
    logic rxBosValid;
    logic rxBosHave;
  } state_s;

  state_s cur;
  state_s next_st;

  logic hitCtrl;
  logic hitStat;
  logic txNow;
  logic inStuff;
  logic idleEff;
  logic fcsEff;
  logic [15:0] crcNew;
  tx_state_e txNs;
  logic [7:0] txLoad;
  logic [15:0] hist;
  logic [2:0] onesNew;
  logic [7:0] byteNow;
  logic fcsOk;
  logic dupHit;
  logic [5:0] codeNow;
  logic storeWrEn;
  logic [7:0] storeRdData;
  logic [STORE_AW-1:0] storeWrAddr;
  logic [STORE_AW-1:0] storeRdAddr;
  logic [5:0] statusWord;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  assign storeWrAddr = {~cur.rxBank, cur.rxByteCnt[5:0]};
  assign storeRdAddr = {cur.rxBank, cur.rxByteCnt[5:0]};
  assign statusWord = {cur.rxBank, cur.rxStoreValid, cur.rxInFrame, cur.txState};

  frame_store store (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .wrEn(storeWrEn),
    .wrAddr(storeWrAddr),
    .wrData(byteNow),
    .rdAddr(storeRdAddr),
    .rdData(storeRdData)
  );

  always_comb begin
    next_st = cur;
    hitCtrl = (paddr == CTRL_ADDR);
    hitStat = (paddr == STATUS_ADDR);
    txNow = cur.txShift[0];
    inStuff = (cur.txState == TX_DATA) || (cur.txState == TX_FCS);
    idleEff = cur.ctrl[BIT_TX_IDLE] & cur.ctrl[BIT_MSG_TYPE];
    fcsEff = cur.ctrl[BIT_TX_CHECK] & cur.ctrl[BIT_MSG_TYPE];
    crcNew = cur.txCrc;
    txNs = TX_FLAG;
    txLoad = FLAG_OCTET;
    hist = {rxBit, cur.rxHist[15:1]};
    onesNew = 3'h0;
    byteNow = {rxBit, cur.rxShift[7:1]};
    fcsOk = 1'b0;
    dupHit = 1'b0;
    codeNow = hist[14:9];
    storeWrEn = 1'b0;
    next_st.txTake = 1'b0;
    next_st.rxDataValid = 1'b0;
    next_st.rxFrameDone = 1'b0;
    next_st.rxFrameAbort = 1'b0;
    next_st.rxFcsError = 1'b0;
    next_st.rxDuplicate = 1'b0;
    next_st.rxBosValid = 1'b0;

    // Register access: answer one cycle after the setup phase.
    next_st.pready = psel & ~penable;
    if (psel && !penable) begin
      next_st.pslverr = ~(hitCtrl | hitStat);
      next_st.prdata = hitCtrl ? 32'(cur.ctrl) : (hitStat ? 32'(statusWord) : 32'(1'b0));
    end
    if (psel && penable && cur.pready && pwrite && hitCtrl) begin
      next_st.ctrl = pwdata[7:0] & CTRL_WRITE_MASK;
    end

    // Transmit serializer, one bit per slot.
    if (dlTick) begin
      if (cur.txOnes == STUFF_RUN) begin
        next_st.txBit = 1'b0;
        next_st.txOnes = 3'h0;
      end else begin
        next_st.txBit = txNow;
        next_st.txOnes = (inStuff && txNow) ? cur.txOnes + 3'h1 : 3'h0;
        if (cur.txState == TX_DATA) begin
          crcNew = crcStep(cur.txCrc, txNow);
        end
        next_st.txCrc = crcNew;
        next_st.txShift = cur.txShift >> 1;
        next_st.txBitCnt = cur.txBitCnt + 3'h1;
        if (cur.txBitCnt == LAST_BIT) begin
          if (cur.ctrl[BIT_TX_ABORT]) begin
            txNs = (cur.txState == TX_ABORT || cur.txState == TX_ONES) ? TX_ONES : TX_ABORT;
          end else if (!cur.ctrl[BIT_MSG_TYPE]) begin
            txNs = (inStuff && !cur.ctrl[BIT_AUTO_ABORT_OFF]) ? TX_ABORT : TX_BOS;
          end else if (idleEff) begin
            txNs = inStuff ? TX_ABORT : TX_FLAG;
          end else if (cur.txState == TX_DATA && cur.txLastSent) begin
            txNs = fcsEff ? TX_FCS : TX_FLAG;
          end else if (cur.txState == TX_FCS) begin
            txNs = cur.txPhase ? TX_FLAG : TX_FCS;
          end else if ((cur.txState == TX_FLAG || cur.txState == TX_DATA) && txMsgValid) begin
            txNs = TX_DATA;
          end else if (cur.txState == TX_DATA) begin
            txNs = TX_ABORT;
          end else begin
            txNs = TX_FLAG;
          end
          next_st.txState = txNs;
          next_st.txPhase = (txNs == cur.txState) ? ~cur.txPhase : 1'b0;
          unique case (txNs)
            TX_FLAG: begin
              txLoad = FLAG_OCTET;
            end
            TX_DATA: begin
              txLoad = txMsgData;
              next_st.txTake = 1'b1;
              next_st.txLastSent = txMsgLast;
              if (cur.txState == TX_FLAG) begin
                next_st.txCrc = CRC_INIT;
              end
            end
            TX_FCS: begin
              txLoad = next_st.txPhase ? ~cur.txCrc[15:8] : ~crcNew[7:0];
            end
            TX_ABORT: begin
              txLoad = ABORT_OCTET;
            end
            TX_ONES: begin
              txLoad = ONES_OCTET;
            end
            TX_BOS: begin
              txLoad = next_st.txPhase ? {1'b0, bosCode, 1'b0} : ONES_OCTET;
            end
            default: begin
              txLoad = FLAG_OCTET;
            end
          endcase
          next_st.txShift = txLoad;
        end
      end
    end

    // Receive deframer, one bit per slot.
    if (dlTick) begin
      next_st.rxHist = hist;
      onesNew = rxBit ? ((cur.rxOnes == ABORT_RUN) ? ABORT_RUN : cur.rxOnes + 3'h1) : 3'h0;
      next_st.rxOnes = onesNew;
      if (hist[15:8] == FLAG_OCTET) begin
        if (cur.rxInFrame && cur.rxByteCnt != 7'h00) begin
          if (cur.rxBitCnt != LAST_BIT) begin
            next_st.rxFrameAbort = 1'b1;
          end else begin
            fcsOk = cur.ctrl[BIT_RX_CHECK_OFF] || (cur.rxCrcAtByte == CRC_RESIDUE);
            dupHit = cur.ctrl[BIT_DUP_DISCARD] && cur.rxStoreValid && cur.rxMatch &&
                     !cur.rxLong && (cur.rxByteCnt == (cur.rxBank ? cur.rxLen1 : cur.rxLen0));
            next_st.rxFrameDone = 1'b1;
            next_st.rxFcsError = ~fcsOk;
            next_st.rxDuplicate = dupHit;
            if (fcsOk && !dupHit) begin
              next_st.rxStoreValid = ~cur.rxLong;
              if (!cur.rxLong) begin
                next_st.rxBank = ~cur.rxBank;
                if (cur.rxBank) begin
                  next_st.rxLen0 = cur.rxByteCnt;
                end else begin
                  next_st.rxLen1 = cur.rxByteCnt;
                end
              end
            end
          end
        end
        next_st.rxInFrame = 1'b1;
        next_st.rxByteCnt = 7'h00;
        next_st.rxBitCnt = 3'h0;
        next_st.rxCrc = CRC_INIT;
        next_st.rxCrcAtByte = CRC_INIT;
        next_st.rxMatch = 1'b1;
        next_st.rxLong = 1'b0;
        next_st.rxOnes = 3'h0;
      end else if (onesNew == ABORT_RUN) begin
        if (cur.rxInFrame && (cur.rxByteCnt != 7'h00 || cur.rxBitCnt != 3'h0)) begin
          next_st.rxFrameAbort = 1'b1;
        end
        next_st.rxInFrame = 1'b0;
      end else if (!rxBit && cur.rxOnes == STUFF_RUN) begin
        next_st.rxOnes = 3'h0;
      end else if (cur.rxInFrame) begin
        next_st.rxShift = byteNow;
        next_st.rxCrc = crcStep(cur.rxCrc, rxBit);
        next_st.rxBitCnt = cur.rxBitCnt + 3'h1;
        if (cur.rxBitCnt == LAST_BIT) begin
          next_st.rxData = byteNow;
          next_st.rxDataValid = 1'b1;
          next_st.rxCrcAtByte = next_st.rxCrc;
          if (cur.rxByteCnt < STORE_LIMIT) begin
            storeWrEn = 1'b1;
            next_st.rxMatch = cur.rxMatch & (storeRdData == byteNow);
          end else begin
            next_st.rxLong = 1'b1;
          end
          if (cur.rxByteCnt != COUNT_MAX) begin
            next_st.rxByteCnt = cur.rxByteCnt + 7'h01;
          end
        end
      end
      if (hist[7:0] == ONES_OCTET && !hist[8] && !hist[15]) begin
        if (!(cur.ctrl[BIT_DUP_DISCARD] && cur.rxBosHave && codeNow == cur.rxBosCode)) begin
          next_st.rxBosValid = 1'b1;
          next_st.rxBosCode = codeNow;
          next_st.rxBosHave = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
      cur.ctrl <= CTRL_RESET;
      cur.txShift <= FLAG_OCTET;
    end else begin
      cur <= next_st;
    end
  end

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign txBit = cur.txBit;
  assign txMsgTake = cur.txTake;
  assign rxData = cur.rxData;
  assign rxDataValid = cur.rxDataValid;
  assign rxFrameDone = cur.rxFrameDone;
  assign rxFrameAbort = cur.rxFrameAbort;
  assign rxFcsError = cur.rxFcsError;
  assign rxDuplicate = cur.rxDuplicate;
  assign rxBosCode = cur.rxBosCode;
  assign rxBosValid = cur.rxBosValid;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  sequence octetEnd;
    dlTick && cur.txOnes != STUFF_RUN && cur.txBitCnt == LAST_BIT;
  endsequence

  sequence mosSwitch;
    (cur.txState == TX_DATA || cur.txState == TX_FCS) && !cur.ctrl[BIT_MSG_TYPE] &&
      !cur.ctrl[BIT_TX_ABORT];
  endsequence

  a_auto_abort: assert property (
    octetEnd ##0 (mosSwitch and !cur.ctrl[BIT_AUTO_ABORT_OFF]) |=>
      cur.txState == TX_ABORT && cur.txShift == ABORT_OCTET)
    else $error("Abort not sent on switch to bit signaling.");

  a_no_abort: assert property (
    octetEnd ##0 (mosSwitch and cur.ctrl[BIT_AUTO_ABORT_OFF]) |=>
      cur.txState == TX_BOS && cur.txShift == ONES_OCTET)
    else $error("Abort sent although automatic abort is off.");

  a_forced_abort: assert property (
    octetEnd ##0 cur.ctrl[BIT_TX_ABORT] |=>
      (cur.txState == TX_ABORT || cur.txState == TX_ONES) && cur.txShift[7:1] == 7'h7F)
    else $error("Forced abort not sent.");

  a_idle_flags: assert property (
    octetEnd ##0 (cur.txState == TX_FLAG && idleEff && !cur.ctrl[BIT_TX_ABORT]) |=>
      cur.txState == TX_FLAG && cur.txShift == FLAG_OCTET && !cur.txTake)
    else $error("Idle flags not sent.");

  a_flag_fill: assert property (
    octetEnd ##0 (cur.txState == TX_FLAG && cur.ctrl[BIT_MSG_TYPE] && !txMsgValid &&
      !cur.ctrl[BIT_TX_ABORT]) |=> cur.txState == TX_FLAG && !cur.txTake)
    else $error("Channel not filled with flags.");

  a_idle_ignored: assert property (
    octetEnd ##0 (!cur.ctrl[BIT_MSG_TYPE] && cur.ctrl[BIT_TX_IDLE] && !cur.ctrl[BIT_TX_ABORT] &&
      !inStuff) |=> cur.txState == TX_BOS)
    else $error("Idle acted under bit signaling.");

  a_fcs_append: assert property (
    octetEnd ##0 (cur.txState == TX_DATA && cur.txLastSent && cur.ctrl[BIT_MSG_TYPE] &&
      !cur.ctrl[BIT_TX_IDLE] && !cur.ctrl[BIT_TX_ABORT]) |=>
      cur.txState == ($past(cur.ctrl[BIT_TX_CHECK]) ? TX_FCS : TX_FLAG) && !cur.txPhase)
    else $error("Check octets wrong at frame end.");

  a_fcs_ignored: assert property (
    octetEnd ##0 (cur.ctrl[BIT_TX_CHECK] && !cur.ctrl[BIT_MSG_TYPE]) |=>
      cur.txState != TX_FCS)
    else $error("Check octets under bit signaling.");

  a_bos_hold: assert property (
    octetEnd ##0 (cur.txState == TX_BOS && !cur.ctrl[BIT_MSG_TYPE] && !cur.ctrl[BIT_TX_ABORT])
      |=> cur.txState == TX_BOS && cur.txPhase == !$past(cur.txPhase))
    else $error("Bit signaling not kept.");

  a_rx_check_off: assert property (
    cur.rxFrameDone && $past(cur.ctrl[BIT_RX_CHECK_OFF]) |-> !cur.rxFcsError)
    else $error("Check error with verification off.");

  a_dup_off: assert property (
    (cur.rxFrameDone || cur.rxBosValid) && !$past(cur.ctrl[BIT_DUP_DISCARD]) |->
      !cur.rxDuplicate && (!cur.rxBosValid || $past(cur.rxBosValid) == 1'b0))
    else $error("Duplicate flagged with discard off.");

  a_ctrl_write: assert property (
    psel && penable && cur.pready && pwrite && hitCtrl |=>
      cur.ctrl == ($past(pwdata[7:0]) & CTRL_WRITE_MASK) && !cur.ctrl[BIT_RESERVED])
    else $error("Control write not taken.");

endmodule

// file: sim/remote_terminal.sv
// Far end of the data link: makes the bit slot strobe and echoes each sent bit back.
module remote_terminal #(
  parameter int TICK_DIV = 4
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic txBit,
  output logic dlTick,
  output logic rxBit,
  output logic [7:0] lastOctet,
  output logic [3:0] onesRun
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= 8'h00;
      dlTick <= 1'b0;
      rxBit <= 1'b0;
      lastOctet <= 8'h00;
      onesRun <= 4'h0;
    end else begin
      dlTick <= (div == 8'(TICK_DIV - 1));
      div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
      if (dlTick) begin
        rxBit <= txBit;
        lastOctet <= {txBit, lastOctet[7:1]};
        onesRun <= txBit ? ((onesRun == 4'hF) ? 4'hF : onesRun + 4'h1) : 4'h0;
      end
    end
  end
endmodule

// file: sim/data_link_two_tb.sv
module data_link_two_tb;
  import data_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, dlTick, txBit, rxBit, txMsgTake;
  logic txMsgValid = 1'b0;
  logic [7:0] txMsgData = 8'h00;
  logic txMsgLast = 1'b0;
  logic [5:0] bosCode = 6'h00;
  logic [7:0] rxData, lastOctet;
  logic rxDataValid, rxFrameDone, rxFrameAbort, rxFcsError, rxDuplicate, rxBosValid;
  logic [5:0] rxBosCode;
  logic [3:0] onesRun;
  logic lastErr = 1'b0;
  logic lastDup = 1'b0;
  logic [7:0] msgMem [0:255];
  int err_count = 0;
  int samples_checked = 0;
  int rxBytes = 0, doneCnt = 0, bosCnt = 0, flagCnt = 0, onesCnt = 0, takeCnt = 0;
  int idx = 0, msgLen = 0;
  int abortCnt = 0;
  logic [31:0] rd;
  logic er;

  always #4 core_clk = ~core_clk;

  data_link_two u_data_link_two (.core_clk(core_clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dlTick(dlTick), .txBit(txBit), .rxBit(rxBit),
    .txMsgValid(txMsgValid), .txMsgData(txMsgData), .txMsgLast(txMsgLast),
    .txMsgTake(txMsgTake), .bosCode(bosCode), .rxData(rxData), .rxDataValid(rxDataValid),
    .rxFrameDone(rxFrameDone), .rxFrameAbort(rxFrameAbort), .rxFcsError(rxFcsError),
    .rxDuplicate(rxDuplicate), .rxBosCode(rxBosCode), .rxBosValid(rxBosValid));

  remote_terminal u_remote_terminal (.core_clk(core_clk), .rst_b(rst_b), .txBit(txBit),
    .dlTick(dlTick), .rxBit(rxBit), .lastOctet(lastOctet), .onesRun(onesRun));

  // Counts receive events and link patterns seen by the far end.
  always @(posedge core_clk) begin
    if (rxDataValid === 1'b1) rxBytes++;
    if (rxBosValid === 1'b1) bosCnt++;
    if (rxFrameAbort === 1'b1) abortCnt++;
    if (dlTick === 1'b1 && lastOctet === FLAG_OCTET) flagCnt++;
    if (dlTick === 1'b1 && onesRun >= 4'h7) onesCnt++;
    if (rxFrameDone === 1'b1) begin
      doneCnt++;
      lastErr = rxFcsError;
      lastDup = rxDuplicate;
    end
  end

  // Hands the next message byte over after each take.
  always @(posedge core_clk) begin
    if (txMsgTake === 1'b1) begin
      takeCnt++;
      if (txMsgLast) txMsgValid <= 1'b0;
      else begin
        idx = idx + 1;
        txMsgData <= msgMem[idx];
        txMsgLast <= (idx == msgLen - 1);
      end
    end
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic hang(input string what);
    err_count++;
    $display("MISMATCH at %0t: timeout in %s", $time, what);
    complete_run();
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("bus");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic start_msg(input int n);
    idx = 0;
    msgLen = n;
    @(posedge core_clk);
    txMsgValid <= 1'b1;
    txMsgData <= msgMem[0];
    txMsgLast <= (n == 1);
  endtask

  task automatic wait_for(input int which, input int lim);
    int c0, n;
    c0 = (which == 0) ? flagCnt : (which == 1) ? onesCnt : bosCnt;
    n = 0;
    while (((which == 0) ? flagCnt : (which == 1) ? onesCnt : bosCnt) == c0 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) hang("link wait");
  endtask

  task automatic t_regs();
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "control reset");
    apb(1'b1, CTRL_ADDR, 32'h0000_0074);
    apb(1'b1, 12'h004, 32'h0000_0001);
    chk(er, 1'b1, "unmapped error");
    apb(1'b0, CTRL_ADDR, 32'h0000_0000);
    chk(rd, 32'h0000_0074, "control readback");
    chk(er, 1'b0, "mapped error");
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    $display("Test registers done");
  endtask

  task automatic t_fill();
    int t0;
    wait_for(0, 600);
    apb(1'b1, CTRL_ADDR, 32'h0000_0005);
    t0 = takeCnt;
    start_msg(3);
    wait_for(0, 600);
    repeat (400) @(posedge core_clk);
    chk(takeCnt - t0, 0, "idle takes");
    txMsgValid <= 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h0000_0009);
    wait_for(1, 600);
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    wait_for(0, 600);
    $display("Test fill done");
  endtask

  task automatic frame_case(input logic [7:0] c, input int nb, input logic e, input logic d);
    int b0, d0, n;
    apb(1'b1, CTRL_ADDR, {24'h00_0000, c});
    b0 = rxBytes;
    d0 = doneCnt;
    start_msg(3);
    n = 0;
    while (doneCnt == d0 && n < 4000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 4000) hang("frame");
    chk(rxBytes - b0, nb, "frame bytes");
    chk({lastErr, lastDup}, {e, d}, "frame flags");
    if (nb == 3) chk(rxData, msgMem[2], "last byte");
  endtask

  task automatic switch_case(input logic [7:0] c, input logic expAbort);
    int n, k, a0;
    logic seen;
    seen = 1'b0;
    apb(1'b1, CTRL_ADDR, 32'h0000_0001);
    start_msg(200);
    n = takeCnt;
    k = 0;
    while (takeCnt < n + 3 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= 2000) hang("message start");
    a0 = abortCnt;
    apb(1'b1, CTRL_ADDR, {24'h00_0000, c});
    n = 0;
    do begin
      apb(1'b0, STATUS_ADDR, 32'h0000_0000);
      if (rd[2:0] === TX_ABORT) seen = 1'b1;
      n++;
    end while (rd[2:0] !== TX_BOS && n < 60);
    txMsgValid <= 1'b0;
    chk({seen, rd[2:0]}, {expAbort, TX_BOS}, "switch abort");
    k = 0;
    while (abortCnt == a0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    chk(abortCnt - a0, 1, "frame cut");
  endtask

  task automatic t_bos();
    bosCode <= 6'h2D;
    apb(1'b1, CTRL_ADDR, 32'h0000_0006);
    wait_for(1, 600);
    wait_for(2, 2000);
    wait_for(2, 2000);
    chk(rxBosCode, 6'h2D, "codeword");
    bosCode <= 6'h12;
    wait_for(2, 2000);
    wait_for(2, 2000);
    chk(rxBosCode, 6'h12, "second codeword");
    $display("Test bit signaling done");
  endtask

  initial begin
    for (int i = 0; i < 256; i++) msgMem[i] = 8'(i * 37 + 17);
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_fill();
    frame_case(8'h03, 5, 1'b0, 1'b0);
    frame_case(8'h13, 5, 1'b0, 1'b1);
    frame_case(8'h03, 5, 1'b0, 1'b0);
    frame_case(8'h01, 3, 1'b1, 1'b0);
    frame_case(8'h21, 3, 1'b0, 1'b0);
    $display("Test frames done");
    switch_case(8'h00, 1'b1);
    switch_case(8'h40, 1'b0);
    $display("Test switch done");
    t_bos();
    complete_run();
  end
endmodule
